/* gpio_mux_pkg.sv */
// Shared constants, register map and types for the multifunction pin block
package gpio_mux_pkg;

	// Sizes of the pin block and of the logic it talks to
	localparam int NUM_PINS      = 8;
	localparam int PIN_IDX_W     = 3;
	localparam int NUM_OUT_CLKS  = 8;
	localparam int NUM_REFS      = 8;
	localparam int NUM_LOOPS     = 4;
	localparam int NUM_LOCK_SRC  = NUM_LOOPS + 1;
	localparam int STICKY_W      = NUM_LOCK_SRC + NUM_LOOPS + NUM_REFS;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 32;
	localparam int MODE_W        = 4;
	localparam int SEL_W         = 3;

	// Sticky vector layout: loss of lock, holdover, loss of signal
	localparam int STK_LOL_LSB   = 0;
	localparam int STK_HO_LSB    = STK_LOL_LSB + NUM_LOCK_SRC;
	localparam int STK_LOS_LSB   = STK_HO_LSB + NUM_LOOPS;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_GP_OUT    = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_GP_IN     = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STICKY    = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_STICKY_CLR = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_ALERT_EN  = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_DCO_STEP  = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_PIN_CFG   = 8'h20;
	localparam int                PIN_CFG_HI_LSB = 5;

	// Control register fields
	localparam int CTRL_ALARM_EN_BIT = 0;
	localparam int CTRL_SUPPLY_LSB   = 1;
	localparam int SUPPLY_W          = 2;

	// Per-pin configuration fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_INV_BIT  = 4;
	localparam int CFG_EN_BIT   = 5;
	localparam int CFG_OD_BIT   = 6;
	localparam int CFG_PD_BIT   = 7;
	localparam int CFG_LOOP_LSB = 8;
	localparam int CFG_REF_LSB  = 12;
	localparam int CFG_MASK_LSB = 16;

	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RESET    = 32'h0000_0001;
	localparam logic [DATA_W-1:0] PIN_CFG_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_ZERO     = 32'h0000_0000;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [MODE_W-1:0] {
		MODE_GP_IN, MODE_GP_OUT, MODE_LOS, MODE_LOL_LIVE, MODE_LOL_STICKY,
		MODE_HO_LIVE, MODE_HO_STICKY, MODE_ALERT, MODE_OUT_DISABLE, MODE_SE_CLOCK,
		MODE_MANUAL_SEL, MODE_DCO_INC, MODE_DCO_DEC, MODE_DISQUALIFY
	} mode_type;

	typedef enum logic [SUPPLY_W-1:0] {
		SUPPLY_1V5, SUPPLY_1V8, SUPPLY_2V5, SUPPLY_3V3
	} supply_type;

endpackage : gpio_mux_pkg

/* pin_sync.sv */
// Two-stage pin synchroniser with rising-edge detect
`timescale 1ns/1ps
module pin_sync
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Pad side
	input  wire logic pad,
	// Synchronised side
	output logic      level,
	output logic      rise
);
	logic meta;
	logic stable;
	logic last;

	// First stage feeds only the second
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end
		else
		begin
			meta   <= pad;
			stable <= meta;
			last   <= stable;
		end
	end

	assign level = stable;
	assign rise  = stable & ~last;

endmodule : pin_sync

/* sticky_bit.sv */
// Sticky flag set by any change of a live alarm
`timescale 1ns/1ps
module sticky_bit
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Live alarm and controls
	input  wire logic live,
	input  wire logic set_enable,
	input  wire logic clear,
	// Latched status
	output logic      sticky
);
	logic last_live;
	logic changed;

	assign changed = (live ^ last_live) & set_enable;

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			last_live <= 1'b0;
			sticky    <= 1'b0;
		end
		else
		begin
			last_live <= live;
			sticky    <= changed | (sticky & ~clear);
		end
	end

endmodule : sticky_bit

/* multifunction_gpio_mux.sv */
// Multifunction pin block: AXI4-Lite registers, per-pin roles and alarm outputs
//
// Behaviour
// - Input mode samples pin into register; default
// - Output mode drives pin from register bit
// - Roles act only after reset sequence done
// - Pins configured alone; same config same output
// - Loss-of-signal pin shows selected live alarm
// - Live lock pin high while loop unlocked
// - Sticky lock pin latches on lock change
// - Live holdover pin high while in holdover
// - Sticky holdover pin latches on holdover change
// - Alert is OR of enabled sticky bits
// - Alert invertible, holds until all enabled bits cleared
// - Disable pin high stops selected output clocks
// - Each disable pin has own output mask
// - Manual select: high picks higher priority reference
// - Rising edge increments selected oscillator channel
// - Rising edge decrements selected oscillator channel
// - High level disqualifies selected reference for loop
// - Per-pin enable, open-drain or push-pull drive
// - Per-pin pull-up or pull-down, pull-up default
// - Alert negates promptly after last clear
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module multifunction_gpio_mux
	import gpio_mux_pkg::*;
(
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [DATA_W-1:0]        s_axi_wdata,
	input  wire logic [DATA_W/8-1:0]      s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [DATA_W-1:0]             s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Device reset sequence status
	input  wire logic                     reset_done,
	// Pins
	input  wire logic [NUM_PINS-1:0]      pad_in,
	output logic [NUM_PINS-1:0]           pad_out,
	output logic [NUM_PINS-1:0]           pad_oe,
	output logic [NUM_PINS-1:0]           pull_up_en,
	output logic [NUM_PINS-1:0]           pull_down_en,
	output logic [SUPPLY_W-1:0]           supply_level,
	// Alarm sources
	input  wire logic [NUM_REFS-1:0]      ref_los_live,
	input  wire logic [NUM_LOOPS-1:0]     dpll_locked,
	input  wire logic                     apll_locked,
	input  wire logic [NUM_LOOPS-1:0]     dpll_holdover,
	// Controls toward clock path
	output logic [NUM_OUT_CLKS-1:0]       out_clk_disable,
	output logic [NUM_LOOPS-1:0]          manual_sel_active,
	output logic [NUM_LOOPS-1:0]          manual_sel_high,
	output logic [NUM_LOOPS-1:0]          dco_inc_pulse,
	output logic [NUM_LOOPS-1:0]          dco_dec_pulse,
	output logic [DATA_W-1:0]             dco_step,
	output logic [NUM_LOOPS*NUM_REFS-1:0] ref_disqualify,
	output logic [NUM_PINS-1:0]           se_clock_in
);
	// Register storage
	logic [DATA_W-1:0]     ctrl;
	logic [NUM_PINS-1:0]   gp_out;
	logic [NUM_PINS-1:0]   gp_in;
	logic [STICKY_W-1:0]   alert_en;
	logic [DATA_W-1:0]     pin_cfg [NUM_PINS];
	logic [STICKY_W-1:0]   sticky;

	// AXI slave state
	logic                  aw_held;
	logic                  w_held;
	logic [ADDR_W-1:0]     aw_addr;
	logic [DATA_W-1:0]     w_data;
	logic [DATA_W/8-1:0]   w_strb;

	// Synchronised pins
	logic [NUM_PINS-1:0]   pin_level;
	logic [NUM_PINS-1:0]   pin_rise;

	// Next values of outputs, all registered except se_clock_in
	logic [NUM_PINS-1:0]         next_pad_out;
	logic [NUM_PINS-1:0]         next_pad_oe;
	logic [NUM_OUT_CLKS-1:0]     next_out_clk_disable;
	logic [NUM_LOOPS-1:0]        next_manual_sel_active;
	logic [NUM_LOOPS-1:0]        next_manual_sel_high;
	logic [NUM_LOOPS-1:0]        next_dco_inc;
	logic [NUM_LOOPS-1:0]        next_dco_dec;
	logic [NUM_LOOPS*NUM_REFS-1:0] next_disqualify;
	logic [NUM_PINS-1:0]         next_se_clock;

	function automatic logic [DATA_W-1:0] byte_mask(input logic [DATA_W/8-1:0] strb);
		logic [DATA_W-1:0] m;
		m = WORD_ZERO;
		for (int b = 0; b < DATA_W/8; b++)
			m[b*8 +: 8] = {8{strb[b]}};
		return m;
	endfunction : byte_mask

	// Write channel: address and data taken in either order
	logic                  aw_fire;
	logic                  w_fire;
	logic                  wr_go;
	logic [ADDR_W-1:0]     wr_addr;
	logic [DATA_W-1:0]     wr_data;
	logic [DATA_W-1:0]     wr_mask;
	logic [PIN_IDX_W-1:0]  wr_pin;
	logic                  wr_is_pin;
	logic                  wr_hit_ctrl;
	logic                  wr_hit_gp_out;
	logic                  wr_hit_clr;
	logic                  wr_hit_alert;
	logic                  wr_hit_step;
	logic                  wr_hit_ro;
	logic                  wr_mapped;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign aw_fire       = s_axi_awvalid & s_axi_awready;
	assign w_fire        = s_axi_wvalid & s_axi_wready;
	assign wr_go         = (aw_held | aw_fire) & (w_held | w_fire) & ~s_axi_bvalid;
	assign wr_addr       = aw_held ? aw_addr : s_axi_awaddr;
	assign wr_data       = w_held ? w_data : s_axi_wdata;
	assign wr_mask       = byte_mask(w_held ? w_strb : s_axi_wstrb);
	assign wr_pin        = wr_addr[2 +: PIN_IDX_W];
	assign wr_is_pin     = wr_addr[ADDR_W-1:PIN_CFG_HI_LSB]
	                       == ADDR_PIN_CFG[ADDR_W-1:PIN_CFG_HI_LSB];
	assign wr_hit_ctrl   = wr_go & (wr_addr == ADDR_CTRL);
	assign wr_hit_gp_out = wr_go & (wr_addr == ADDR_GP_OUT);
	assign wr_hit_clr    = wr_go & (wr_addr == ADDR_STICKY_CLR);
	assign wr_hit_alert  = wr_go & (wr_addr == ADDR_ALERT_EN);
	assign wr_hit_step   = wr_go & (wr_addr == ADDR_DCO_STEP);
	assign wr_hit_ro     = (wr_addr == ADDR_GP_IN) | (wr_addr == ADDR_STICKY);
	assign wr_mapped     = wr_is_pin | wr_hit_ro | (wr_addr == ADDR_CTRL)
	                       | (wr_addr == ADDR_GP_OUT) | (wr_addr == ADDR_STICKY_CLR)
	                       | (wr_addr == ADDR_ALERT_EN) | (wr_addr == ADDR_DCO_STEP);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= WORD_ZERO;
			w_strb       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else
		begin
			aw_held <= (aw_held | aw_fire) & ~wr_go;
			w_held  <= (w_held | w_fire) & ~wr_go;
			if (aw_fire)
				aw_addr <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes, byte lanes honoured
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrl     <= CTRL_RESET;
			gp_out   <= '0;
			alert_en <= '0;
			dco_step <= WORD_ZERO;
		end
		else
		begin
			if (wr_hit_ctrl)
				ctrl <= (ctrl & ~wr_mask) | (wr_data & wr_mask);
			if (wr_hit_gp_out)
				gp_out <= (gp_out & ~wr_mask[NUM_PINS-1:0]) | (wr_data[NUM_PINS-1:0]
				          & wr_mask[NUM_PINS-1:0]);
			if (wr_hit_alert)
				alert_en <= (alert_en & ~wr_mask[STICKY_W-1:0])
				            | (wr_data[STICKY_W-1:0] & wr_mask[STICKY_W-1:0]);
			if (wr_hit_step)
				dco_step <= (dco_step & ~wr_mask) | (wr_data & wr_mask);
		end
	end

	// Pin config words, reset to input mode with pull-up
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : pin_regs
			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
					pin_cfg[g] <= PIN_CFG_RESET;
				else if (wr_go & wr_is_pin & (wr_pin == PIN_IDX_W'(g)))
					pin_cfg[g] <= (pin_cfg[g] & ~wr_mask) | (wr_data & wr_mask);
			end

			pin_sync sync_inst
			(
				.clock (clock),
				.rst   (rst),
				.pad   (pad_in[g]),
				.level (pin_level[g]),
				.rise  (pin_rise[g])
			);
		end
	endgenerate

	// Read channel, answer one cycle after the address is taken
	logic                 ar_fire;
	logic [PIN_IDX_W-1:0] rd_pin;
	logic                 rd_is_pin;
	logic [DATA_W-1:0]    rd_word;
	logic                 rd_mapped;

	assign s_axi_arready = ~s_axi_rvalid;
	assign ar_fire       = s_axi_arvalid & s_axi_arready;
	assign rd_pin        = s_axi_araddr[2 +: PIN_IDX_W];
	assign rd_is_pin     = s_axi_araddr[ADDR_W-1:PIN_CFG_HI_LSB]
	                       == ADDR_PIN_CFG[ADDR_W-1:PIN_CFG_HI_LSB];
	assign rd_word =
		rd_is_pin                          ? pin_cfg[rd_pin] :
		(s_axi_araddr == ADDR_CTRL)        ? ctrl :
		(s_axi_araddr == ADDR_GP_OUT)      ? DATA_W'(gp_out) :
		(s_axi_araddr == ADDR_GP_IN)       ? DATA_W'(gp_in) :
		(s_axi_araddr == ADDR_STICKY)      ? DATA_W'(sticky) :
		(s_axi_araddr == ADDR_ALERT_EN)    ? DATA_W'(alert_en) :
		(s_axi_araddr == ADDR_DCO_STEP)    ? dco_step : WORD_ZERO;
	assign rd_mapped = rd_is_pin | (s_axi_araddr == ADDR_CTRL)
	                   | (s_axi_araddr == ADDR_GP_OUT) | (s_axi_araddr == ADDR_GP_IN)
	                   | (s_axi_araddr == ADDR_STICKY) | (s_axi_araddr == ADDR_STICKY_CLR)
	                   | (s_axi_araddr == ADDR_ALERT_EN) | (s_axi_araddr == ADDR_DCO_STEP);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= WORD_ZERO;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Input level register follows the synchronised pins
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			gp_in <= '0;
		else
			gp_in <= pin_level;
	end

	// Live alarms; lock needs both the loop and the analog loop locked
	logic [NUM_LOCK_SRC-1:0] lol_live;
	logic [STICKY_W-1:0]     live_vec;
	logic [STICKY_W-1:0]     clear_vec;

	assign lol_live  = {~apll_locked, ~(dpll_locked & {NUM_LOOPS{apll_locked}})};
	assign live_vec  = {ref_los_live, dpll_holdover, lol_live};
	assign clear_vec = wr_hit_clr ? (wr_data[STICKY_W-1:0] & wr_mask[STICKY_W-1:0])
	                              : '0;

	// One shared flag per source keeps equally set pins identical
	generate
		for (g = 0; g < STICKY_W; g++)
		begin : stickies
			sticky_bit sticky_inst
			(
				.clock      (clock),
				.rst        (rst),
				.live       (live_vec[g]),
				.set_enable (ctrl[CTRL_ALARM_EN_BIT]),
				.clear      (clear_vec[g]),
				.sticky     (sticky[g])
			);
		end
	endgenerate

	// Alert drops in the same cycle as the last enabled flag clears
	logic alert_any;
	assign alert_any = |(sticky & alert_en);

	assign supply_level = ctrl[CTRL_SUPPLY_LSB +: SUPPLY_W];

	// Per-pin role decode and aggregation across pins
	always_comb
	begin
		mode_type              mode;
		logic [SEL_W-1:0]      loop_sel;
		logic [SEL_W-1:0]      ref_sel;
		logic                  active;
		logic                  drives;
		logic                  value;
		logic                  od;
		mode      = MODE_GP_IN;
		loop_sel  = '0;
		ref_sel   = '0;
		active    = 1'b0;
		drives    = 1'b0;
		value     = 1'b0;
		od        = 1'b0;
		next_pad_out           = '0;
		next_pad_oe            = '0;
		next_out_clk_disable   = '0;
		next_manual_sel_active = '0;
		next_manual_sel_high   = '0;
		next_dco_inc           = '0;
		next_dco_dec           = '0;
		next_disqualify        = '0;
		next_se_clock          = '0;
		for (int p = 0; p < NUM_PINS; p++)
		begin
			mode     = mode_type'(pin_cfg[p][CFG_MODE_LSB +: MODE_W]);
			loop_sel = pin_cfg[p][CFG_LOOP_LSB +: SEL_W];
			ref_sel  = pin_cfg[p][CFG_REF_LSB +: SEL_W];
			active   = reset_done & pin_cfg[p][CFG_EN_BIT];
			od       = pin_cfg[p][CFG_OD_BIT];
			drives   = 1'b1;
			value    = 1'b0;
			unique case (mode)
				MODE_GP_IN:
					drives = 1'b0;
				MODE_GP_OUT:
					value = gp_out[p];
				MODE_LOS:
					value = ref_los_live[ref_sel];
				MODE_LOL_LIVE:
					value = (int'(loop_sel) < NUM_LOCK_SRC)
					        & lol_live[loop_sel];
				MODE_LOL_STICKY:
					value = (int'(loop_sel) < NUM_LOCK_SRC)
					        & sticky[STK_LOL_LSB + int'(loop_sel)];
				MODE_HO_LIVE:
					value = (int'(loop_sel) < NUM_LOOPS)
					        & dpll_holdover[loop_sel[1:0]];
				MODE_HO_STICKY:
					value = (int'(loop_sel) < NUM_LOOPS)
					        & sticky[STK_HO_LSB + int'(loop_sel[1:0])];
				MODE_ALERT:
					value = alert_any;
				MODE_OUT_DISABLE:
				begin
					drives = 1'b0;
					if (active & pin_level[p])
						next_out_clk_disable = next_out_clk_disable
						    | pin_cfg[p][CFG_MASK_LSB +: NUM_OUT_CLKS];
				end
				MODE_SE_CLOCK:
				begin
					drives = 1'b0;
					next_se_clock[p] = active & pad_in[p];
				end
				MODE_MANUAL_SEL:
				begin
					drives = 1'b0;
					if (active & (int'(loop_sel) < NUM_LOOPS))
					begin
						next_manual_sel_active[loop_sel[1:0]] = 1'b1;
						next_manual_sel_high[loop_sel[1:0]]   = pin_level[p];
					end
				end
				MODE_DCO_INC:
				begin
					drives = 1'b0;
					if (active & pin_rise[p] & (int'(loop_sel) < NUM_LOOPS))
						next_dco_inc[loop_sel[1:0]] = 1'b1;
				end
				MODE_DCO_DEC:
				begin
					drives = 1'b0;
					if (active & pin_rise[p] & (int'(loop_sel) < NUM_LOOPS))
						next_dco_dec[loop_sel[1:0]] = 1'b1;
				end
				MODE_DISQUALIFY:
				begin
					drives = 1'b0;
					if (active & pin_level[p] & (int'(loop_sel) < NUM_LOOPS))
						next_disqualify[int'(loop_sel[1:0]) * NUM_REFS + int'(ref_sel)]
						    = 1'b1;
				end
				default:
					drives = 1'b0;
			endcase
			// Alarm roles may be inverted; plain output is not
			if (mode != MODE_GP_OUT)
				value = value ^ pin_cfg[p][CFG_INV_BIT];
			// Open drain only ever pulls low
			next_pad_out[p] = ~od & value;
			next_pad_oe[p]  = active & drives & (~od | ~value);
		end
	end

	// Clock stage inputs bypass the synchroniser
	assign se_clock_in = next_se_clock;

	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : pulls
			assign pull_up_en[g]   = ~pin_cfg[g][CFG_PD_BIT];
			assign pull_down_en[g] = pin_cfg[g][CFG_PD_BIT];
		end
	endgenerate

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pad_out           <= '0;
			pad_oe            <= '0;
			out_clk_disable   <= '0;
			manual_sel_active <= '0;
			manual_sel_high   <= '0;
			dco_inc_pulse     <= '0;
			dco_dec_pulse     <= '0;
			ref_disqualify    <= '0;
		end
		else
		begin
			pad_out           <= next_pad_out;
			pad_oe            <= next_pad_oe;
			out_clk_disable   <= next_out_clk_disable;
			manual_sel_active <= next_manual_sel_active;
			manual_sel_high   <= next_manual_sel_high;
			dco_inc_pulse     <= next_dco_inc;
			dco_dec_pulse     <= next_dco_dec;
			ref_disqualify    <= next_disqualify;
		end
	end

endmodule : multifunction_gpio_mux

/* gpio_mux_chk_sva.sv */
// Port-level assertions for the multifunction pin block
`timescale 1ns/1ps
module gpio_mux_chk
	import gpio_mux_pkg::*;
(
	// Clock and reset
	input wire logic                clock,
	input wire logic                rst,
	input wire logic                reset_done,
	// Pins
	input wire logic [NUM_PINS-1:0] pad_oe,
	input wire logic [NUM_PINS-1:0] pull_up_en,
	input wire logic [NUM_PINS-1:0] pull_down_en,
	// Register bus handshakes
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	// Oscillator steps
	input wire logic [NUM_LOOPS-1:0] dco_inc_pulse,
	input wire logic [NUM_LOOPS-1:0] dco_dec_pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_answer; s_wr_taken |=> s_axi_bvalid; endproperty
	property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
	property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_hold_off; !reset_done |=> pad_oe == '0; endproperty
	property p_pulls; pull_up_en == ~pull_down_en; endproperty
	// Edges on one pin need a low pin between them, so pulses from one pin never touch
	property p_inc_pulse;
		dco_inc_pulse != '0 |=> (dco_inc_pulse & $past(dco_inc_pulse)) == '0;
	endproperty
	property p_dec_pulse;
		dco_dec_pulse != '0 |=> (dco_dec_pulse & $past(dco_dec_pulse)) == '0;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	a_b_once: assert property (p_b_once) else $error("write answer repeated");
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_r_once: assert property (p_r_once) else $error("read answer repeated");
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	a_hold_off: assert property (p_hold_off) else $error("pin driven early");
	a_pulls: assert property (p_pulls) else $error("pull select wrong");
	a_inc_pulse: assert property (p_inc_pulse) else $error("step up too long");
	a_dec_pulse: assert property (p_dec_pulse) else $error("step down too long");
endmodule : gpio_mux_chk

bind multifunction_gpio_mux gpio_mux_chk i_chk (.clock, .rst, .reset_done, .pad_oe,
	.pull_up_en, .pull_down_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .dco_inc_pulse, .dco_dec_pulse);

/* board_pin_model.sv */
// Board side of the pins: external drivers and pad pulls
`timescale 1ns/1ps
module board_pin_model
	import gpio_mux_pkg::*;
(
	// Device pad side
	input  wire logic [NUM_PINS-1:0] pad_out,
	input  wire logic [NUM_PINS-1:0] pad_oe,
	input  wire logic [NUM_PINS-1:0] pull_up_en,
	// Board drivers
	input  wire logic [NUM_PINS-1:0] ext_lvl,
	input  wire logic [NUM_PINS-1:0] ext_en,
	// Resolved level
	output logic      [NUM_PINS-1:0] pad_in
);
	// Undriven pin floats to its pull, never to a stale value
	always_comb
		for (int i = 0; i < NUM_PINS; i++)
			pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_lvl[i] : pull_up_en[i]);
endmodule : board_pin_model

/* tb_top.sv */
// Self-checking bench for the multifunction pin block
`timescale 1ns/1ps
module tb_top
	import gpio_mux_pkg::*;
;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic                 clock, rst, reset_done, apll_locked;
	logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata, dco_step, ref_disqualify;
	logic [3:0]           s_axi_wstrb;
	logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                 s_axi_rvalid, s_axi_rready;
	logic [1:0]           s_axi_bresp, s_axi_rresp, supply_level;
	logic [NUM_PINS-1:0]  pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, se_clock_in;
	logic [NUM_PINS-1:0]  ext_lvl, ext_en, out_clk_disable, ref_los_live;
	logic [NUM_LOOPS-1:0] dpll_locked, dpll_holdover, manual_sel_active, manual_sel_high;
	logic [NUM_LOOPS-1:0] dco_inc_pulse, dco_dec_pulse;
	int                   bad_count, num_checks, inc_cnt, dec_cnt;
	// No single-ended clock role
	logic [31:0] cfg_a [8] = '{32'h21, 32'h61, 32'h5022, 32'h5022, 32'h5032, 32'h124,
		32'h27, 32'h123};

	multifunction_gpio_mux i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_done, .pad_in, .pad_out, .pad_oe,
		.pull_up_en, .pull_down_en, .supply_level, .ref_los_live, .dpll_locked, .apll_locked,
		.dpll_holdover, .out_clk_disable, .manual_sel_active, .manual_sel_high,
		.dco_inc_pulse, .dco_dec_pulse, .dco_step, .ref_disqualify, .se_clock_in);
	board_pin_model i_board (.pad_out, .pad_oe, .pull_up_en, .ext_lvl, .ext_en, .pad_in);

	initial
	begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock)
	begin
		inc_cnt <= inc_cnt + int'(dco_inc_pulse == 4'h4);
		dec_cnt <= dec_cnt + int'(dco_dec_pulse == 4'h8);
	end

	task automatic check(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw_done && w_done))
		begin
			@(posedge clock);
			aw_done |= s_axi_awready;
			w_done |= s_axi_wready;
			s_axi_awvalid <= !aw_done;
			s_axi_wvalid <= !w_done;
		end
		do @(posedge clock); while (!s_axi_bvalid);
		check(32'(s_axi_bresp), 32'(r));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, m = ALL,
		input logic [1:0] r = RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clock); while (!s_axi_rvalid);
		check(s_axi_rdata & m, e);
		check(32'(s_axi_rresp), 32'(r));
	endtask : rd

	task automatic cfg(input logic [2:0] p, input logic [31:0] v);
		wr(ADDR_PIN_CFG + {p, 2'h0}, v);
	endtask : cfg

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (5000) @(posedge clock);
		bad_count++;
		final_report();
	end

	initial
	begin
		{rst, apll_locked, s_axi_bready, s_axi_rready, s_axi_wstrb} = 8'hFF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, reset_done} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{ext_lvl, ref_los_live, dpll_holdover, inc_cnt, dec_cnt} = '0;
		{ext_en, dpll_locked} = 12'hFCF;
		repeat (20) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		rd(ADDR_CTRL, CTRL_RESET);
		rd(ADDR_PIN_CFG, PIN_CFG_RESET);
		check(32'(pull_up_en), 32'hFF);
		rd(8'h1C, WORD_ZERO, ALL, RESP_SLVERR);
		wr(8'h40, ALL, RESP_SLVERR);
		wr(ADDR_CTRL, 32'h7);
		check(32'(supply_level), 32'(SUPPLY_3V3));
		$display("Test registers done");
		for (int i = 0; i < 8; i++)
			cfg(3'(i), cfg_a[i]);
		wr(ADDR_GP_OUT, 32'h1);
		wr(ADDR_ALERT_EN, 32'h2);
		tick(4);
		check(32'(pad_oe), 32'h0);
		reset_done <= 1'h1;
		tick(4);
		check(32'(pad_oe), 32'hFF);
		check(32'(pad_out), 32'h11);
		wr(ADDR_GP_OUT, 32'h3);
		tick(3);
		check(32'(pad_oe[1:0]), 32'h1);
		$display("Test outputs done");
		ref_los_live <= 8'h20;
		dpll_locked <= 4'hD;
		tick(4);
		check(32'(pad_out[7:2]), 32'h3B);
		rd(ADDR_STICKY, 32'h4002);
		wr(ADDR_STICKY_CLR, 32'h2);
		tick(2);
		check(32'(pad_out[7:5]), 32'h4);
		dpll_locked <= 4'hF;
		tick(4);
		check(32'(pad_out[7:5]), 32'h3);
		cfg(5, 32'h26);
		cfg(7, 32'h25);
		wr(ADDR_STICKY_CLR, 32'h1FFFF);
		dpll_holdover <= 4'h1;
		tick(4);
		check(32'(pad_out[7:5]), 32'h5);
		$display("Test alarms done");
		ext_lvl <= 8'hE4;
		cfg(2, 32'hA50028);
		cfg(3, 32'h22B);
		cfg(4, 32'h32C);
		cfg(5, 32'h20);
		cfg(6, 32'h12A);
		cfg(7, 32'h622D);
		tick(5);
		check(32'(out_clk_disable), 32'hA5);
		check(32'({manual_sel_active, manual_sel_high}), 32'h22);
		check(ref_disqualify, 32'h400000);
		rd(ADDR_GP_IN, 32'h20, 32'h20);
		ext_lvl <= 8'h20;
		tick(5);
		check(32'(out_clk_disable), 32'h0);
		check(32'({manual_sel_active, manual_sel_high}), 32'h20);
		wr(ADDR_DCO_STEP, 32'h1234);
		check(dco_step, 32'h1234);
		repeat (2)
		begin
			ext_lvl[4:3] <= 2'h3;
			tick(4);
			ext_lvl[4:3] <= 2'h0;
			tick(4);
		end
		check(32'(inc_cnt), 32'h2);
		check(32'(dec_cnt), 32'h2);
		$display("Test input roles done");
		final_report();
	end
endmodule : tb_top
